// ---- i2ccfg_core_model.sv ----
// Model of the I2C core: reports busy, FIFO level and bytes left.
// Assumes a one-cycle start from the bench and the command pulses of the block.
`timescale 1ns/100ps
module i2ccfg_core_model (
  input wire logic                    ref_clk,
  input wire logic                    sys_rst,
  input wire logic                    go,
  input wire logic [3:0]              words,
  input wire i2ccfg_pkg::i2ccfg_cmd_s cmd,
  output logic                        busy,
  output logic [3:0]                  level,
  output logic [9:0]                  left
);
  logic [1:0] tick_reg;
  // Frame owes one word less than the FIFO holds, so the byte count caps the level
  assign left = (level == 4'h0) ? 10'h000 : {4'h0, level - 4'h1, 2'b00};
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      level <= 4'h0;
      tick_reg <= 2'h0;
    end else if (cmd.queue_purge || cmd.engine_restart) begin
      busy <= 1'b0;
      level <= 4'h0;
    end else if (go) begin
      busy <= 1'b1;
      level <= words;
    end else if (busy) begin
      tick_reg <= tick_reg + 2'h1;
      if (tick_reg == 2'h3) begin
        level <= level - 4'h1;
        busy <= level != 4'h1;
      end
    end
  end
endmodule

// ---- i2ccfg_level_trigger.sv ----
// Compares the FIFO level against a trigger, counting in whole words.
// Assumes a level in words and the remaining byte count from the core.
`timescale 1ns/100ps
module i2ccfg_level_trigger #(
  parameter int LEN_W = 10,
  parameter int LVL_W = 4,
  parameter int TRIG_W = 3
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              enable,
  input  wire logic [TRIG_W-1:0] trigger,
  input  wire logic [LVL_W-1:0]  fifo_level,
  input  wire logic [LEN_W-1:0]  bytes_left,
  output logic                   hit
);
  import i2ccfg_pkg::*;

  i2ccfg_lvl_e state_reg;
  logic [LVL_W-1:0] eff_level;
  logic [LEN_W-1:0] words_left;
  logic [LEN_W:0]   sum_wide;

  // Last word of a frame may hold 1..4 bytes; level counts only words still owed
  // Widened sum keeps a long frame from wrapping to a small word count
  always_comb begin
    sum_wide   = {1'b0, bytes_left} + (LEN_W+1)'(3);
    words_left = LEN_W'(sum_wide >> 2);
    eff_level  = fifo_level;
    if (LEN_W'(fifo_level) > words_left)
      eff_level = LVL_W'(words_left);
  end

  // Pulse once on each arrival at the trigger level
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= LVL_IDLE;
      hit       <= 1'b0;
    end else begin
      hit <= 1'b0;
      case (state_reg)
        LVL_IDLE: begin
          if (enable)
            state_reg <= LVL_ARMED;
        end
        LVL_ARMED: begin
          if (!enable)
            state_reg <= LVL_IDLE;
          else if (eff_level == LVL_W'(trigger)) begin
            state_reg <= LVL_HIT;
            hit       <= 1'b1;
          end
        end
        LVL_HIT: begin
          if (!enable)
            state_reg <= LVL_IDLE;
          else if (eff_level != LVL_W'(trigger))
            state_reg <= LVL_ARMED;
        end
        default: state_reg <= LVL_IDLE;
      endcase
    end
  end
endmodule

// ---- i2ccfg_pkg.sv ----
// Package for the I2C master configuration register block.
// Holds offsets, field positions, reset values and shared types; no assumptions.
package i2ccfg_pkg;

  localparam int          I2CCFG_AW             = 8;
  localparam int          I2CCFG_DW             = 32;

  localparam logic [7:0]  OFS_CONTROL_CONFIG    = 8'h00;
  localparam logic [7:0]  OFS_CLOCK_DIVIDER     = 8'h04;
  localparam logic [7:0]  OFS_HOLD_TIME         = 8'h08;
  localparam logic [7:0]  OFS_TARGET_ADDRESS    = 8'h0C;
  localparam logic [7:0]  OFS_FIFO_LEVEL_TRIG   = 8'h10;
  localparam logic [7:0]  OFS_TRANSFER_LENGTH   = 8'h14;
  localparam logic [7:0]  OFS_ENGINE_STATUS     = 8'h18;
  localparam logic [7:0]  OFS_IRQ_STATUS        = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_MASK          = 8'h20;

  localparam int          BIT_DIRECTION         = 0;
  localparam int          BIT_ADDR_WIDTH        = 1;
  localparam int          BIT_QUEUE_PURGE       = 2;
  localparam int          BIT_SETTINGS_RESTORE  = 3;
  localparam int          BIT_ENGINE_RESTART    = 4;

  localparam int          DIV_W                 = 8;
  localparam int          HOLD_W                = 5;
  localparam int          ADDR_W                = 10;
  localparam int          TRIG_W                = 3;
  localparam int          LEN_W                 = 10;
  localparam int          LVL_W                 = 4;
  localparam int          TX_TRIG_LSB           = 0;
  localparam int          RX_TRIG_LSB           = 8;

  localparam logic [7:0]  RST_DIVIDER           = 8'hF4;
  localparam logic [4:0]  RST_HOLD              = 5'h09;
  localparam logic [9:0]  RST_ADDRESS           = 10'h02A;
  localparam logic [2:0]  RST_TX_TRIG           = 3'h1;
  localparam logic [2:0]  RST_RX_TRIG           = 3'h7;
  localparam logic [9:0]  RST_LENGTH            = 10'h000;

  localparam int          IRQ_TX_LEVEL          = 0;
  localparam int          IRQ_RX_LEVEL          = 1;
  localparam int          IRQ_W                 = 2;

  // Register port request from software
  typedef struct packed {
    logic [I2CCFG_AW-1:0] addr;
    logic [I2CCFG_DW-1:0] wdata;
    logic                 wr;
    logic                 rd;
  } i2ccfg_req_s;

  // Settings handed to the I2C core
  typedef struct packed {
    logic              direction_select;
    logic              address_width_select;
    logic [DIV_W-1:0]  scl_rate_divider;
    logic [HOLD_W-1:0] hold_count;
    logic [ADDR_W-1:0] target_address;
    logic [LEN_W-1:0]  transfer_length_setting;
  } i2ccfg_cfg_s;

  // One-cycle commands to the core and FIFO
  typedef struct packed {
    logic queue_purge;
    logic settings_restore;
    logic engine_restart;
  } i2ccfg_cmd_s;

  typedef enum logic [1:0] {
    LVL_IDLE  = 2'b00,
    LVL_ARMED = 2'b01,
    LVL_HIT   = 2'b11
  } i2ccfg_lvl_e;

endpackage

// ---- i2ccfg_pulse.sv ----
// One-cycle command pulse from a software write of one.
// Assumes the write strobe lasts exactly one clock.
`timescale 1ns/100ps
module i2ccfg_pulse (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic fire,
  output logic      pulse
);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      pulse <= 1'b0;
    else
      pulse <= fire;
  end
endmodule

// ---- i2ccfg_regs.sv ----
// Configuration registers of a bus-side I2C master with level interrupts.
// Assumes a core that reports busy, FIFO level and remaining byte count.
`timescale 1ns/100ps
module i2ccfg_regs (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire i2ccfg_pkg::i2ccfg_req_s req,
  output logic [31:0]                 rdata,
  input  wire logic                   xfer_busy,
  input  wire logic [3:0]             fifo_level,
  input  wire logic [9:0]             bytes_left,
  output i2ccfg_pkg::i2ccfg_cfg_s     cfg,
  output i2ccfg_pkg::i2ccfg_cmd_s     cmd,
  output logic                        irq
);
  import i2ccfg_pkg::*;

  logic              direction_reg;
  logic              addr_width_reg;
  logic [DIV_W-1:0]  divider_reg;
  logic [HOLD_W-1:0] hold_reg;
  logic [ADDR_W-1:0] address_reg;
  logic [TRIG_W-1:0] tx_trig_reg;
  logic [TRIG_W-1:0] rx_trig_reg;
  logic [LEN_W-1:0]  length_reg;
  logic [IRQ_W-1:0]  irq_status_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic [IRQ_W-1:0]  irq_event;
  logic              restore;
  logic              purge_pulse;
  logic              restart_pulse;
  logic              tx_hit;
  logic              rx_hit;
  logic              wr_cfg;
  logic              wr_div;
  logic              wr_hold;
  logic              wr_addr;
  logic              wr_trig;
  logic              wr_len;

  function automatic logic sel(input logic [I2CCFG_AW-1:0] a, input logic [7:0] ofs);
    sel = req.wr && (a == ofs);
  endfunction

  always_comb begin
    wr_cfg  = sel(req.addr, OFS_CONTROL_CONFIG) && !xfer_busy;
    wr_div  = sel(req.addr, OFS_CLOCK_DIVIDER) && !xfer_busy;
    wr_hold = sel(req.addr, OFS_HOLD_TIME) && !xfer_busy;
    wr_addr = sel(req.addr, OFS_TARGET_ADDRESS) && !xfer_busy;
    wr_trig = sel(req.addr, OFS_FIFO_LEVEL_TRIG);
    wr_len  = sel(req.addr, OFS_TRANSFER_LENGTH);
  end

  // Command bits never store; each makes a single-cycle pulse
  i2ccfg_pulse u_purge (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .fire    (wr_cfg && req.wdata[BIT_QUEUE_PURGE]),
    .pulse   (purge_pulse)
  );

  i2ccfg_pulse u_restore (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .fire    (wr_cfg && req.wdata[BIT_SETTINGS_RESTORE]),
    .pulse   (restore)
  );

  i2ccfg_pulse u_restart (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .fire    (wr_cfg && req.wdata[BIT_ENGINE_RESTART]),
    .pulse   (restart_pulse)
  );

  // One driver for the whole command word
  always_comb begin
    cmd.queue_purge      = purge_pulse;
    cmd.settings_restore = restore;
    cmd.engine_restart   = restart_pulse;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      direction_reg  <= 1'b0;
      addr_width_reg <= 1'b0;
    end else if (wr_cfg) begin
      direction_reg  <= req.wdata[BIT_DIRECTION];
      addr_width_reg <= req.wdata[BIT_ADDR_WIDTH];
    end
  end

  // Restore pulse lands one cycle after the write; a write in that cycle loses
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divider_reg <= RST_DIVIDER;
      hold_reg    <= RST_HOLD;
      address_reg <= RST_ADDRESS;
      tx_trig_reg <= RST_TX_TRIG;
      rx_trig_reg <= RST_RX_TRIG;
      length_reg  <= RST_LENGTH;
    end else if (restore) begin
      divider_reg <= RST_DIVIDER;
      hold_reg    <= RST_HOLD;
      address_reg <= RST_ADDRESS;
      tx_trig_reg <= RST_TX_TRIG;
      rx_trig_reg <= RST_RX_TRIG;
      length_reg  <= RST_LENGTH;
    end else begin
      if (wr_div)
        divider_reg <= req.wdata[DIV_W-1:0];
      if (wr_hold)
        hold_reg <= req.wdata[HOLD_W-1:0];
      if (wr_addr)
        address_reg <= req.wdata[ADDR_W-1:0];
      if (wr_trig) begin
        tx_trig_reg <= req.wdata[TX_TRIG_LSB +: TRIG_W];
        rx_trig_reg <= req.wdata[RX_TRIG_LSB +: TRIG_W];
      end
      if (wr_len)
        length_reg <= req.wdata[LEN_W-1:0];
    end
  end

  always_comb begin
    cfg.direction_select        = direction_reg;
    cfg.address_width_select    = addr_width_reg;
    cfg.scl_rate_divider        = divider_reg;
    cfg.hold_count              = hold_reg;
    cfg.target_address          = address_reg;
    cfg.transfer_length_setting = length_reg;
  end

  i2ccfg_level_trigger #(
    .LEN_W  (LEN_W),
    .LVL_W  (LVL_W),
    .TRIG_W (TRIG_W)
  ) u_tx_trig (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .enable     (xfer_busy && !direction_reg),
    .trigger    (tx_trig_reg),
    .fifo_level (fifo_level),
    .bytes_left (bytes_left),
    .hit        (tx_hit)
  );

  i2ccfg_level_trigger #(
    .LEN_W  (LEN_W),
    .LVL_W  (LVL_W),
    .TRIG_W (TRIG_W)
  ) u_rx_trig (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .enable     (xfer_busy && direction_reg),
    .trigger    (rx_trig_reg),
    .fifo_level (fifo_level),
    .bytes_left (bytes_left),
    .hit        (rx_hit)
  );

  always_comb begin
    irq_event               = '0;
    irq_event[IRQ_TX_LEVEL] = tx_hit;
    irq_event[IRQ_RX_LEVEL] = rx_hit;
  end

  // Sticky status; a new event beats a same-cycle write-one clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      irq_status_reg <= '0;
    else if (sel(req.addr, OFS_IRQ_STATUS))
      irq_status_reg <= (irq_status_reg & ~req.wdata[IRQ_W-1:0]) | irq_event;
    else
      irq_status_reg <= irq_status_reg | irq_event;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      irq_mask_reg <= '0;
    else if (sel(req.addr, OFS_IRQ_MASK))
      irq_mask_reg <= req.wdata[IRQ_W-1:0];
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read data valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      rdata <= 32'h0000_0000;
      case (req.addr)
        OFS_CONTROL_CONFIG: begin
          rdata[BIT_DIRECTION]  <= direction_reg;
          rdata[BIT_ADDR_WIDTH] <= addr_width_reg;
        end
        OFS_CLOCK_DIVIDER:   rdata[DIV_W-1:0] <= divider_reg;
        OFS_HOLD_TIME:       rdata[HOLD_W-1:0] <= hold_reg;
        OFS_TARGET_ADDRESS:  rdata[ADDR_W-1:0] <= address_reg;
        OFS_FIFO_LEVEL_TRIG: begin
          rdata[TX_TRIG_LSB +: TRIG_W] <= tx_trig_reg;
          rdata[RX_TRIG_LSB +: TRIG_W] <= rx_trig_reg;
        end
        OFS_TRANSFER_LENGTH: rdata[LEN_W-1:0] <= length_reg;
        OFS_ENGINE_STATUS: begin
          rdata[0] <= xfer_busy;
          rdata[1] <= direction_reg;
          rdata[11:8] <= fifo_level;
        end
        OFS_IRQ_STATUS:      rdata[IRQ_W-1:0] <= irq_status_reg;
        OFS_IRQ_MASK:        rdata[IRQ_W-1:0] <= irq_mask_reg;
        default:             rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ---- i2ccfg_regs_assertions.sv ----
// Checker of the configuration register block, bound to its ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/100ps
module i2ccfg_regs_checker (
  input wire logic                    ref_clk,
  input wire logic                    sys_rst,
  input wire i2ccfg_pkg::i2ccfg_req_s req,
  input wire logic [31:0]             rdata,
  input wire logic                    xfer_busy,
  input wire i2ccfg_pkg::i2ccfg_cfg_s cfg,
  input wire i2ccfg_pkg::i2ccfg_cmd_s cmd
);
  import i2ccfg_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic free_w;
  logic cfg_w;
  assign free_w = req.wr && !xfer_busy && !cmd.settings_restore;
  assign cfg_w = req.wr && !xfer_busy && req.addr == OFS_CONTROL_CONFIG;

  dir_write_a: assert property (free_w && req.addr == OFS_CONTROL_CONFIG |=>
    {cfg.address_width_select, cfg.direction_select} == $past(req.wdata[1:0])) else $error("config bits wrong");
  purge_pulse_a: assert property (cfg_w && req.wdata[2] |=> cmd.queue_purge) else $error("no purge pulse");
  restore_pulse_a: assert property (cfg_w && req.wdata[3] |=> cmd.settings_restore ##1
    (cfg.scl_rate_divider == RST_DIVIDER && cfg.hold_count == RST_HOLD && cfg.target_address == RST_ADDRESS
     && cfg.transfer_length_setting == RST_LENGTH)) else $error("restore failed");
  restart_pulse_a: assert property (cfg_w && req.wdata[4] |=> cmd.engine_restart) else $error("no restart");
  pulse_cause_a: assert property (cmd != '0 |-> $past(cfg_w)) else $error("pulse without write");
  div_write_a: assert property (free_w && req.addr == OFS_CLOCK_DIVIDER |=>
    cfg.scl_rate_divider == $past(req.wdata[7:0])) else $error("divider write lost");
  hold_write_a: assert property (free_w && req.addr == OFS_HOLD_TIME |=>
    cfg.hold_count == $past(req.wdata[4:0])) else $error("hold write lost");
  addr_write_a: assert property (free_w && req.addr == OFS_TARGET_ADDRESS |=>
    cfg.target_address == $past(req.wdata[9:0])) else $error("address write lost");
  busy_hold_a: assert property (req.wr && xfer_busy && !cmd.settings_restore |=>
    $stable(cfg.scl_rate_divider) && $stable(cfg.target_address) && $stable(cfg.direction_select))
    else $error("write taken while busy");
  unmapped_read_a: assert property (req.rd && req.addr == 8'h30 |=> rdata == '0) else $error("unmapped read");
endmodule

// ---- tb.sv ----
// Self-checking bench of the configuration register block with a core model.
// Assumes the package offsets and the one-cycle read latency of the port.
`timescale 1ns/100ps
module tb;
  import i2ccfg_pkg::*;
  logic        ref_clk = 0;
  logic        sys_rst = 1;
  i2ccfg_req_s req = '0;
  logic [31:0] rdata;
  logic        busy;
  logic        go = 0;
  logic [3:0]  lvl;
  logic [9:0]  left;
  i2ccfg_cfg_s cfg;
  i2ccfg_cmd_s cmd;
  logic        irq;
  logic [31:0] ex [6];
  logic [31:0] seed = 32'h40fe;
  logic [31:0] got;
  int          bad_count = 0;
  int          checks_done = 0;
  initial forever #5 ref_clk = ~ref_clk;
  i2ccfg_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .xfer_busy(busy),
    .fifo_level(lvl), .bytes_left(left), .cfg(cfg), .cmd(cmd), .irq(irq));
  i2ccfg_core_model core (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go), .words(4'h3), .cmd(cmd),
    .busy(busy), .level(lvl), .left(left));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] msk(int i);
    return i == 0 ? 32'h3 : i == 1 ? 32'hff : i == 2 ? 32'h1f : i == 4 ? 32'h707 : 32'h3ff;
  endfunction
  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic defaults(bit all);
    if (all) ex[0] = 0;
    ex[1] = 32'(RST_DIVIDER);
    ex[2] = 32'(RST_HOLD);
    ex[3] = 32'(RST_ADDRESS);
    ex[4] = {21'h0, RST_RX_TRIG, 5'h0, RST_TX_TRIG};
    ex[5] = 32'(RST_LENGTH);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int i;
    i = a >> 2;
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    #1;
    if (i < 6 && a[1:0] == 2'b00 && !(busy && i < 4)) begin
      ex[i] = d & msk(i);
      if (i == 0 && d[3]) defaults(0);
    end
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic chk_all();
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      cmp($sformatf("reg %0h", i * 4), ex[i], got);
    end
    cmp("dir", ex[0], {30'h0, cfg.address_width_select, cfg.direction_select});
    cmp("div", ex[1], 32'(cfg.scl_rate_divider));
    cmp("hold", ex[2], 32'(cfg.hold_count));
    cmp("addr", ex[3], 32'(cfg.target_address));
  endtask
  task automatic run();
    int n;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    wr(OFS_CLOCK_DIVIDER, 32'h55);
    for (n = 0; n < 100 && busy; n++) @(posedge ref_clk);
    if (busy) begin
      bad_count++;
      tally_and_finish();
    end
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic stat(logic [31:0] s, logic q);
    rd(OFS_IRQ_STATUS);
    cmp("irq status", s, got);
    cmp("irq line", 32'(q), 32'(irq));
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    defaults(1);
    chk_all();
    rd(8'h30);
    cmp("unmapped", 0, got);
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      wr(8'(k % 6 * 4), seed);
      if (k % 6 == 5) chk_all();
    end
    wr(OFS_CLOCK_DIVIDER, 32'h0a);
    wr(OFS_HOLD_TIME, 32'h0);
    for (int b = 2; b < 5; b++) wr(OFS_CONTROL_CONFIG, 32'(1 << b));
    chk_all();
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_CONTROL_CONFIG, 32'h1);
    wr(OFS_FIFO_LEVEL_TRIG, 32'h700);
    run();
    stat(0, 0);
    wr(OFS_FIFO_LEVEL_TRIG, 32'h201);
    run();
    stat(2, 1);
    wr(OFS_FIFO_LEVEL_TRIG, 32'h200);
    wr(OFS_CONTROL_CONFIG, 32'h0);
    run();
    stat(3, 1);
    wr(OFS_IRQ_MASK, 32'h0);
    stat(3, 0);
    wr(OFS_IRQ_MASK, 32'h1);
    stat(3, 1);
    wr(OFS_IRQ_STATUS, 32'h3);
    stat(0, 0);
    chk_all();
    tally_and_finish();
  end
endmodule
bind i2ccfg_regs i2ccfg_regs_checker chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
  .xfer_busy(xfer_busy), .cfg(cfg), .cmd(cmd));
